// file: logic/ccr_top.sv
// shadowed configuration registers plus the output data path they steer
// assumes a serial-port core on clk issuing one-cycle reg_wr/reg_rd strobes
//
// Function
// - setting transfer bit copies all shadow values into active registers together.
// - shadowed writes change only readback until transfer; transfer bit then clears itself.
// - local writes go to indexed channels; dual-select read returns channel A.
// - internal power code 00/11 normal, 01 full power-down, 10 standby.
// - global bit picks power-down pin action: 0 full power-down, 1 standby.
// - global clock bit 0 enables duty-cycle stabilizer, set after reset.
// - clock divide field divides input clock by field value plus one.
// - any divide code except 000 forces duty-cycle stabilization on.
// - test field picks off, midscale, +FS, -FS, checkerboard, PN long/short, toggle.
// - selected test pattern replaces converted samples on output data pins.
// - separate test bits hold long and short PN generators at their seeds.
// - global output type bit: 0 CMOS, 1 LVDS.
// - output mode holds interleave bit and per-channel enable-bar and invert bits.
// - format code 00/11 offset binary, 01 twos complement, 10 Gray.
// - bit 7 of output mode picks full or reduced drive strength.
// - divider phase field delays divider input by 0 to 7 input clocks.
`timescale 1ns/1ps
`default_nettype none
module ccr_top
	import ccr_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [12:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic pdwn_pin,
	input wire logic [1:0][13:0] sample,
	output logic [1:0][13:0] dout,
	output ccr_glb_t glb_active,
	output ccr_ch_t [1:0] ch_active,
	output ccr_pwr_t [1:0] ch_power,
	output logic dcs_on,
	output logic [3:0] div_ratio
);
	// ==========================================================
	// helpers
	function automatic ccr_pwr_t pwr_dec(input logic [1:0] code);
		case (code)
			2'b01: pwr_dec = PWR_OFF;
			2'b10: pwr_dec = PWR_STBY;
			default: pwr_dec = PWR_NORMAL;
		endcase
	endfunction

	function automatic ccr_ch_t ch_wr(input ccr_ch_t c, input logic [12:0] a, input logic [7:0] d);
		ch_wr = c;
		case (a)
			ADDR_PWR: ch_wr.pwr = d[1:0];
			ADDR_TEST:
			begin
				ch_wr.pnl_rst = d[PNL_BIT];
				ch_wr.pns_rst = d[PNS_BIT];
				ch_wr.test = d[2:0];
			end
			ADDR_TRIM: ch_wr.trim = d[5:0];
			ADDR_OUT:
			begin
				ch_wr.oe_n = d[OEN_BIT];
				ch_wr.inv = d[INV_BIT];
				ch_wr.fmt = d[1:0];
			end
			default: ch_wr = c;
		endcase
	endfunction

	function automatic logic [13:0] fmt_apply(input logic [13:0] v, input logic [1:0] f, input logic inv);
		logic [13:0] r;
		r = v;
		case (f)
			FMT_TWOS: r = {~v[13], v[12:0]};
			FMT_GRAY: r = v ^ (v >> 1);
			default: r = v;
		endcase
		fmt_apply = inv ? ~r : r;
	endfunction

	// ==========================================================
	// shadow and active registers
	ccr_ch_t [1:0] sh_q;
	ccr_glb_t gsh_q;
	logic [1:0] chan_q;
	logic xfer_q;
	ccr_glb_t gsh_d;
	wire xfer_cmd = reg_wr && reg_addr == ADDR_XFER && reg_wdata[XFER_BIT];
	wire [12:0] a = reg_addr;
	wire [7:0] d = reg_wdata;

	always_comb
	begin
		gsh_d = gsh_q;
		if (reg_wr)
		begin
			case (a)
				ADDR_PWR: gsh_d.pin_stby = d[PIN_FN_BIT];
				ADDR_GCLK: gsh_d.dcs = d[DCS_BIT];
				ADDR_DIV: gsh_d.div = d[2:0];
				ADDR_OUT:
				begin
					gsh_d.drive = d[DRIVE_BIT];
					gsh_d.otype = d[OTYPE_BIT];
					gsh_d.ileave = d[ILV_BIT];
				end
				ADDR_PHASE:
				begin
					gsh_d.dco_inv = d[DCO_INV_BIT];
					gsh_d.phase = d[2:0];
				end
				default: gsh_d = gsh_q;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sh_q <= {CH_RST, CH_RST};
			gsh_q <= GLB_RST;
			chan_q <= CHAN_RST;
		end
		else
		begin
			gsh_q <= gsh_d;
			if (reg_wr && a == ADDR_CHAN)
				chan_q <= d[1:0];
			for (int c = 0; c < 2; c++)
				if (reg_wr && chan_q[c])
					sh_q[c] <= ch_wr(sh_q[c], a, d);
		end
	end

	// active copies move only on the cycle the transfer bit is seen set
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			xfer_q <= 1'b0;
			ch_active <= {CH_RST, CH_RST};
			glb_active <= GLB_RST;
		end
		else
		begin
			xfer_q <= xfer_cmd;
			if (xfer_q)
			begin
				ch_active <= sh_q;
				glb_active <= gsh_q;
			end
		end
	end

	// ==========================================================
	// readback shows shadow contents; channel A wins when both are selected
	wire rc = !chan_q[0];
	ccr_ch_t rch;
	logic [7:0] rd_d;
	assign rch = sh_q[rc];

	always_comb
	begin
		case (a)
			ADDR_CHAN: rd_d = {6'h00, chan_q};
			ADDR_PWR: rd_d = {2'b00, gsh_q.pin_stby, 3'b000, rch.pwr};
			ADDR_GCLK: rd_d = {7'h00, gsh_q.dcs};
			ADDR_DIV: rd_d = {5'h00, gsh_q.div};
			ADDR_TEST: rd_d = {2'b00, rch.pnl_rst, rch.pns_rst, 1'b0, rch.test};
			ADDR_TRIM: rd_d = {2'b00, rch.trim};
			ADDR_OUT: rd_d = {gsh_q.drive, gsh_q.otype, gsh_q.ileave, rch.oe_n, 1'b0, rch.inv, rch.fmt};
			ADDR_PHASE: rd_d = {gsh_q.dco_inv, 4'h0, gsh_q.phase};
			ADDR_XFER: rd_d = {7'h00, xfer_q};
			default: rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rd_d;
	end

	// ==========================================================
	// power-down pin: a level is accepted once stages two and three agree
	logic [2:0] pin_s_q;
	logic pd_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pin_s_q <= 3'b000;
			pd_q <= 1'b0;
		end
		else
		begin
			pin_s_q <= {pin_s_q[1:0], pdwn_pin};
			if (pin_s_q[1] == pin_s_q[2])
				pd_q <= pin_s_q[2];
		end
	end

	// ==========================================================
	// power state and clock controls; the divider itself sits in the clock path outside
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ch_power <= '{PWR_NORMAL, PWR_NORMAL};
			dcs_on <= 1'b1;
			div_ratio <= 4'h1;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
				if (pd_q)
					ch_power[c] <= glb_active.pin_stby ? PWR_STBY : PWR_OFF;
				else
					ch_power[c] <= pwr_dec(ch_active[c].pwr);
			dcs_on <= glb_active.dcs || glb_active.div != 3'b000;
			div_ratio <= {1'b0, glb_active.div} + 4'h1;
		end
	end
	// leave through glb_active and ch_active unchanged

	// ==========================================================
	// pattern generators and output data path
	logic [1:0][22:0] pnl_q;
	logic [1:0][8:0] pns_q;
	logic tog_q;
	logic [1:0][13:0] pat;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pnl_q <= {PNL_SEED, PNL_SEED};
			pns_q <= {PNS_SEED, PNS_SEED};
			tog_q <= 1'b0;
		end
		else
		begin
			tog_q <= !tog_q;
			for (int c = 0; c < 2; c++)
			begin
				pnl_q[c] <= ch_active[c].pnl_rst ? PNL_SEED
					: {pnl_q[c][21:0], pnl_q[c][22] ^ pnl_q[c][17]};
				pns_q[c] <= ch_active[c].pns_rst ? PNS_SEED
					: {pns_q[c][7:0], pns_q[c][8] ^ pns_q[c][4]};
			end
		end
	end

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			case (ch_active[c].test)
				TM_MID: pat[c] = PAT_MID;
				TM_POS: pat[c] = PAT_POS;
				TM_NEG: pat[c] = PAT_NEG;
				TM_CHK: pat[c] = tog_q ? ~PAT_CHK : PAT_CHK;
				TM_PNL: pat[c] = pnl_q[c][13:0];
				TM_PNS: pat[c] = {pns_q[c], pns_q[c][8:4]};
				TM_TOGGLE: pat[c] = tog_q ? PAT_NEG : PAT_POS;
				default: pat[c] = sample[c];
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			dout <= '0;
		else
			for (int c = 0; c < 2; c++)
				dout[c] <= fmt_apply(pat[c], ch_active[c].fmt, ch_active[c].inv);
	end

	// ==========================================================
	// checks
	sequence s_xfer_cmd;
		reg_wr && reg_addr == ADDR_XFER && reg_wdata[XFER_BIT];
	endsequence

	sequence s_xfer_done;
		xfer_q ##1 !xfer_q;
	endsequence

	property p_xfer_copy;
		@(posedge clk) disable iff (reset)
		xfer_q |=> ch_active == $past(sh_q) && glb_active == $past(gsh_q);
	endproperty
	a_xfer_copy: assert property (p_xfer_copy) else $error("active not loaded on transfer");

	property p_xfer_clear;
		@(posedge clk) disable iff (reset)
		!xfer_cmd |=> !xfer_q;
	endproperty
	a_xfer_clear: assert property (p_xfer_clear) else $error("transfer bit did not clear");

	property p_hold;
		@(posedge clk) disable iff (reset)
		!xfer_q |=> $stable(ch_active) && $stable(glb_active);
	endproperty
	a_hold: assert property (p_hold) else $error("active changed without transfer");

	property p_cmd_seq;
		@(posedge clk) disable iff (reset)
		s_xfer_cmd ##1 !xfer_cmd |-> s_xfer_done;
	endproperty
	a_cmd_seq: assert property (p_cmd_seq) else $error("transfer pulse wrong");

	property p_both;
		@(posedge clk) disable iff (reset)
		reg_wr && reg_addr == ADDR_TEST && chan_q == 2'b11 |=> sh_q[0].test == sh_q[1].test;
	endproperty
	a_both: assert property (p_both) else $error("dual channel write differs");

	property p_pwr_off;
		@(posedge clk) disable iff (reset)
		!pd_q && ch_active[0].pwr == 2'b01 |=> ch_power[0] == PWR_OFF;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power-down code not decoded");

	property p_pin;
		@(posedge clk) disable iff (reset)
		pd_q |=> ch_power[1] == ($past(glb_active.pin_stby) ? PWR_STBY : PWR_OFF);
	endproperty
	a_pin: assert property (p_pin) else $error("pin power action wrong");

	property p_dcs;
		@(posedge clk) disable iff (reset)
		glb_active.div != 3'b000 |=> dcs_on;
	endproperty
	a_dcs: assert property (p_dcs) else $error("stabilizer not forced");

	property p_div;
		@(posedge clk) disable iff (reset)
		1'b1 |=> div_ratio == {1'b0, $past(glb_active.div)} + 4'h1;
	endproperty
	a_div: assert property (p_div) else $error("divide ratio wrong");

	property p_pos;
		@(posedge clk) disable iff (reset)
		ch_active[0].test == TM_POS && ch_active[0].fmt == 2'b00 && !ch_active[0].inv |=> dout[0] == PAT_POS;
	endproperty
	a_pos: assert property (p_pos) else $error("pattern not on outputs");
endmodule // ccr_top
`default_nettype wire

// file: logic/ccr_pkg.sv
// constants, field layouts and carrier types for the converter config registers
// assumes a serial-port core that presents one parallel byte access per transaction
`default_nettype none
package ccr_pkg;
	// ==========================================================
	// addresses and field positions
	localparam logic [12:0] ADDR_CHAN = 13'h0005;
	localparam logic [12:0] ADDR_PWR = 13'h0008;
	localparam logic [12:0] ADDR_GCLK = 13'h0009;
	localparam logic [12:0] ADDR_DIV = 13'h000b;
	localparam logic [12:0] ADDR_TEST = 13'h000d;
	localparam logic [12:0] ADDR_TRIM = 13'h0010;
	localparam logic [12:0] ADDR_OUT = 13'h0014;
	localparam logic [12:0] ADDR_PHASE = 13'h0016;
	localparam logic [12:0] ADDR_XFER = 13'h00ff;
	localparam int XFER_BIT = 0;
	localparam int PIN_FN_BIT = 5;
	localparam int DCS_BIT = 0;
	localparam int PNL_BIT = 5;
	localparam int PNS_BIT = 4;
	localparam int DRIVE_BIT = 7;
	localparam int OTYPE_BIT = 6;
	localparam int ILV_BIT = 5;
	localparam int OEN_BIT = 4;
	localparam int INV_BIT = 2;
	localparam int DCO_INV_BIT = 7;
	// ==========================================================
	// reset values and pattern words
	localparam logic [1:0] CHAN_RST = 2'h3;
	localparam logic [13:0] PAT_MID = 14'h2000;
	localparam logic [13:0] PAT_POS = 14'h3fff;
	localparam logic [13:0] PAT_NEG = 14'h0000;
	localparam logic [13:0] PAT_CHK = 14'h2aaa;
	localparam logic [22:0] PNL_SEED = 23'h7f_ffff;
	localparam logic [8:0] PNS_SEED = 9'h1ff;
	// ==========================================================
	// modes
	typedef enum logic [1:0] {PWR_NORMAL = 2'b00, PWR_OFF = 2'b01, PWR_STBY = 2'b10} ccr_pwr_t;
	typedef enum logic [1:0] {FMT_OBIN = 2'b00, FMT_TWOS = 2'b01, FMT_GRAY = 2'b10} ccr_fmt_t;
	typedef enum logic [2:0] {
		TM_OFF = 3'b000, TM_MID = 3'b001, TM_POS = 3'b010, TM_NEG = 3'b011,
		TM_CHK = 3'b100, TM_PNL = 3'b101, TM_PNS = 3'b110, TM_TOGGLE = 3'b111
	} ccr_test_t;
	typedef struct packed {
		logic [1:0] pwr;
		logic pnl_rst;
		logic pns_rst;
		logic [2:0] test;
		logic [5:0] trim;
		logic oe_n;
		logic inv;
		logic [1:0] fmt;
	} ccr_ch_t;
	typedef struct packed {
		logic pin_stby;
		logic dcs;
		logic [2:0] div;
		logic [2:0] phase;
		logic dco_inv;
		logic drive;
		logic otype;
		logic ileave;
	} ccr_glb_t;
	localparam ccr_ch_t CH_RST = '0;
	localparam ccr_glb_t GLB_RST = '{dcs: 1'b1, default: '0};
endpackage
`default_nettype wire

// file: test/ccr_testbench.sv
// self-checking bench for the shadowed converter configuration registers
// assumes ccr_pkg and ccr_top are compiled first; drives every port itself
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ccr_pkg::*;
;
	// ==========================================================
	// signals and design instance
	logic clk;
	logic reset;
	logic reg_wr;
	logic reg_rd;
	logic [12:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic pdwn_pin;
	logic [1:0][13:0] sample;
	logic [1:0][13:0] dout;
	ccr_glb_t glb_active;
	ccr_ch_t [1:0] ch_active;
	ccr_pwr_t [1:0] ch_power;
	logic dcs_on;
	logic [3:0] div_ratio;
	logic [13:0] d1;
	int n_errors;
	int comparisons;
	int cycles;
	// last two addresses are unmapped and must read zero
	logic [12:0] ra [10] = '{ADDR_CHAN, ADDR_PWR, ADDR_GCLK, ADDR_DIV, ADDR_TEST, ADDR_TRIM, ADDR_OUT,
		ADDR_PHASE, 13'h0003, 13'h0100};
	logic [7:0] rv [10] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	ccr_top i_ccr_top (
		.clk(clk),
		.reset(reset),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.pdwn_pin(pdwn_pin),
		.sample(sample),
		.dout(dout),
		.glb_active(glb_active),
		.ch_active(ch_active),
		.ch_power(ch_power),
		.dcs_on(dcs_on),
		.div_ratio(div_ratio)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// access tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// strobes rise and fall in different time steps, so back-to-back calls leave a gap cycle
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		@(posedge clk);
		#1;
		chk("reg_rdata", exp, reg_rdata);
	endtask

	// active copy lands two edges after the write, outputs one edge later
	task automatic xfer;
		wr(ADDR_XFER, 8'h01);
		repeat (3) @(posedge clk);
		#1;
	endtask

	function automatic logic [13:0] fmt_exp(input logic [13:0] s, input logic [1:0] f);
		case (f)
			2'b01: return s ^ 14'h2000;
			2'b10: return s ^ (s >> 1);
			default: return s;
		endcase
	endfunction

	task automatic results;
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			results();
		end
	end

	// ==========================================================
	// main sequence
	initial
	begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 13'h0000;
		reg_wdata = 8'h00;
		pdwn_pin = 1'b0;
		sample = {14'h1555, 14'h0abc};
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'b0;
		chk("glb_active", GLB_RST, glb_active);
		chk("ch_active a", 32'h0000_0000, ch_active[0]);
		chk("ch_active b", 32'h0000_0000, ch_active[1]);
		chk("dcs_on", 1, dcs_on);
		chk("div_ratio", 1, div_ratio);
		for (int i = 0; i < 10; i++)
			rdchk(ra[i], rv[i]);
		// pending write must not reach the outputs before the transfer
		wr(ADDR_TEST, 8'h02);
		chk("test pending", 0, ch_active[0].test);
		chk("dout pending", sample[0], dout[0]);
		rdchk(ADDR_TEST, 8'h02);
		xfer();
		chk("test active", 2, ch_active[0].test);
		chk("dout a pos", PAT_POS, dout[0]);
		chk("dout b pos", PAT_POS, dout[1]);
		rdchk(ADDR_XFER, 8'h00);
		// channel index steers local writes and dual-select reads
		wr(ADDR_CHAN, 8'h01);
		wr(ADDR_TEST, 8'h01);
		wr(ADDR_CHAN, 8'h02);
		wr(ADDR_TEST, 8'h03);
		wr(ADDR_CHAN, 8'h03);
		rdchk(ADDR_TEST, 8'h01);
		wr(ADDR_CHAN, 8'h02);
		rdchk(ADDR_TEST, 8'h03);
		xfer();
		chk("dout a mid", PAT_MID, dout[0]);
		chk("dout b neg", PAT_NEG, dout[1]);
		wr(ADDR_CHAN, 8'h03);
		// checkerboard and toggle flip every bit each cycle
		for (int c = 4; c < 8; c += 3)
		begin
			wr(ADDR_TEST, 8'(c));
			xfer();
			d1 = dout[0];
			@(posedge clk);
			#1;
			chk("alternating", 14'h3fff, d1 ^ dout[0]);
		end
		// generators held at their seed must give a frozen output
		for (int c = 0; c < 2; c++)
		begin
			wr(ADDR_TEST, (c == 0) ? 8'h25 : 8'h16);
			xfer();
			chk("pnl_rst", (c == 0), ch_active[0].pnl_rst);
			chk("pns_rst", (c == 1), ch_active[1].pns_rst);
			d1 = dout[0];
			repeat (2) @(posedge clk);
			#1;
			chk("pn held", d1, dout[0]);
		end
		wr(ADDR_TEST, 8'h00);
		for (int f = 0; f < 4; f++)
		begin
			wr(ADDR_OUT, 8'(f));
			xfer();
			chk("format", fmt_exp(sample[0], 2'(f)), dout[0]);
		end
		wr(ADDR_OUT, 8'hf5);
		xfer();
		chk("drive", 1, glb_active.drive);
		chk("otype", 1, glb_active.otype);
		chk("ileave", 1, glb_active.ileave);
		chk("oe_n", 1, ch_active[1].oe_n);
		chk("dout inv", 14'(~fmt_exp(sample[1], 2'b01)), dout[1]);
		wr(ADDR_OUT, 8'h00);
		xfer();
		chk("otype clr", 0, glb_active.otype);
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_PWR, 8'(c));
			xfer();
			chk("ch_power", (c == 1) ? PWR_OFF : ((c == 2) ? PWR_STBY : PWR_NORMAL), ch_power[0]);
		end
		// pin passes a synchroniser, so allow it a few cycles
		for (int b = 0; b < 2; b++)
		begin
			wr(ADDR_PWR, 8'(b << 5));
			xfer();
			pdwn_pin = 1'b1;
			repeat (8) @(posedge clk);
			#1;
			chk("pin power", (b == 1) ? PWR_STBY : PWR_OFF, ch_power[1]);
			pdwn_pin = 1'b0;
			repeat (8) @(posedge clk);
			#1;
		end
		wr(ADDR_GCLK, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			wr(ADDR_DIV, 8'(c));
			wr(ADDR_PHASE, 8'(c));
			xfer();
			chk("div_ratio", c + 1, div_ratio);
			chk("dcs_on", (c != 0), dcs_on);
			chk("dcs bit", 0, glb_active.dcs);
			chk("phase", c, glb_active.phase);
		end
		wr(ADDR_GCLK, 8'h01);
		wr(ADDR_DIV, 8'h00);
		xfer();
		chk("dcs enable", 1, dcs_on);
		results();
	end
endmodule // testbench
`default_nettype wire
